// [verilog/video_cmd_pkg.sv]
// Opcodes, field layouts, reset values and timing constants of the video command registers
package video_cmd_pkg;
  localparam longint CLK_HZ = 125_000_000;
  localparam longint NTSC_SC_HZ = 3_579_545;
  localparam longint PAL_SC_HZ = 4_433_618;
  localparam logic [31:0] NTSC_SC_INC = 32'((NTSC_SC_HZ * (64'd1 << 32)) / CLK_HZ);
  localparam logic [31:0] PAL_SC_INC = 32'((PAL_SC_HZ * (64'd1 << 32)) / CLK_HZ);

  localparam logic [7:0] OP_MAIN_CTRL = 8'h2d;
  localparam logic [7:0] OP_U_TABLE = 8'h2e;
  localparam logic [7:0] OP_V_TABLE = 8'h2f;
  localparam logic [7:0] OP_PROGRAM = 8'h30;
  localparam logic [7:0] OP_COPY_ADDR = 8'h34;
  localparam logic [7:0] OP_STATUS = 8'h53;

  localparam logic [5:0] LEN_16 = 6'h10;
  localparam logic [5:0] LEN_32 = 6'h20;
  localparam logic [5:0] LEN_40 = 6'h28;
  localparam logic [5:0] OPCODE_BITS = 6'h08;

  localparam int MC_VIDEO_ON_BIT = 15;
  localparam int MC_PAL_BIT = 14;
  localparam int MC_RUN_HI = 13;
  localparam int MC_RUN_LO = 10;
  localparam int MC_LINES_HI = 9;
  localparam int MC_LINES_LO = 0;

  localparam int CP_SRC_HI = 39;
  localparam int CP_SRC_LO = 24;
  localparam int CP_TGT_HI = 23;
  localparam int CP_TGT_LO = 8;
  localparam int CP_LOWPASS_BIT = 4;
  localparam int CP_CURRENT_BIT = 3;
  localparam int CP_SRC_LSB_BIT = 2;
  localparam int CP_TGT_LSB_BIT = 1;

  localparam logic [15:0] MAIN_CTRL_RST = 16'h0000;
  localparam logic [15:0] TABLE_RST = 16'h0000;
  localparam logic [31:0] PROGRAM_RST = 32'h0000_0000;
  localparam logic [39:0] COPY_ADDR_RST = 40'h00_0000_0000;

  localparam logic [4:0] PROTO_RUN_TICKS = 5'h08;
  localparam logic [3:0] UV_MAX_BITS = 4'h6;

  typedef enum logic [1:0] {PICK_U, PICK_V, PICK_Y, PICK_NONE} pick_code_t;

  typedef struct packed {
    pick_code_t pick_code;
    logic [2:0] bit_count;
    logic [2:0] shift_amount;
  } step_t;

  typedef struct packed {
    logic synth_locked;
    logic copy_active_flag;
    logic [3:0] unused;
    logic [9:0] current_line;
  } status_t;

  typedef enum {RUN_IDLE, RUN_EXEC} run_state_t;
endpackage

// [verilog/video_gen_command_registers.sv]
// Serial command registers and picture sequencer of the composite video generator
`timescale 1ns/1ps
module video_gen_command_registers #(
  parameter int PIXEL_DIV = 8,
  parameter int LINE_PIXELS = 640
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic sck_i,
  input wire logic serial_select_n_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_o,
  input wire logic synth_locked_i,
  input wire logic copy_active_i,
  input wire logic chroma_translate_on_i,
  input wire logic protoline_i,
  input wire logic [13:0] pic_index_start_i,
  input wire logic [15:0] sram_data_i,
  output logic sram_req_o,
  output logic [16:0] line_index_addr_o,
  output logic index_restart_o,
  output logic video_on_o,
  output logic pal_select_o,
  output logic pixel_tick_o,
  output logic subcarrier_tick_o,
  output logic [7:0] y_o,
  output logic [5:0] u_o,
  output logic [5:0] v_o,
  output logic luma_lowpass_on_o,
  output logic output_current_high_o,
  output logic [16:0] copy_source_o,
  output logic [16:0] copy_target_o,
  output logic copy_busy_pin_o,
  output logic [9:0] current_line_o
);
  import video_cmd_pkg::*;

  function automatic logic [5:0] op_length(input logic [7:0] op);
    case (op)
      OP_MAIN_CTRL, OP_U_TABLE, OP_V_TABLE: op_length = LEN_16;
      OP_PROGRAM: op_length = LEN_32;
      OP_COPY_ADDR: op_length = LEN_40;
      default: op_length = 6'h00;
    endcase
  endfunction

  function automatic logic [3:0] table_entry(input logic [15:0] tab, input logic [1:0] idx);
    table_entry = tab[{idx, 2'b00} +: 4];
  endfunction

  function automatic logic [7:0] low_mask(input logic [3:0] n);
    low_mask = 8'((9'h001 << n) - 9'h001);
  endfunction

  // ---------------- Serial link domain ----------------
  logic [5:0] bit_cnt;
  logic [46:0] frame_sr;
  logic [7:0] op_q;
  logic [7:0] cmd_op;
  logic [39:0] cmd_data;
  logic cmd_toggle;
  logic read_mode;
  logic so_q;
  status_t stat_hold;
  logic [5:0] next_bit_cnt;
  logic [7:0] next_op;

  assign next_bit_cnt = (bit_cnt == 6'h3f) ? bit_cnt : bit_cnt + 6'h01;
  assign next_op = {frame_sr[6:0], si_i};

  // Frame position is cleared by the select pin itself, so a stray edge count never leaks into the next frame
  always_ff @(posedge sck_i or posedge serial_select_n_i) begin
    if (serial_select_n_i) begin
      bit_cnt <= 6'h00;
      op_q <= 8'h00;
    end else begin
      bit_cnt <= next_bit_cnt;
      if (bit_cnt == OPCODE_BITS - 6'h01) begin
        op_q <= next_op;
      end
    end
  end

  always_ff @(posedge sck_i or posedge rst_i) begin
    if (rst_i) begin
      frame_sr <= '0;
    end else begin
      frame_sr <= {frame_sr[45:0], si_i};
    end
  end

  // MSB-first payload capture
  // Payload is frozen once its last bit arrives; further clocks in the frame are ignored
  always_ff @(posedge sck_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_op <= 8'h00;
      cmd_data <= '0;
      cmd_toggle <= 1'b0;
    end else if (!serial_select_n_i && op_length(op_q) != 6'h00 &&
                 bit_cnt == OPCODE_BITS + op_length(op_q) - 6'h01) begin
      cmd_op <= op_q;
      cmd_data <= {frame_sr[38:0], si_i};
      cmd_toggle <= ~cmd_toggle;
    end
  end

  always_ff @(posedge sck_i or posedge serial_select_n_i) begin
    if (serial_select_n_i) begin
      read_mode <= 1'b0;
    end else if (bit_cnt == OPCODE_BITS - 6'h01 && next_op == OP_STATUS) begin
      read_mode <= 1'b1;
    end
  end

  // Mode 0: output changes on the falling edge so it is stable at the host's rising sample
  always_ff @(negedge sck_i or posedge serial_select_n_i) begin
    if (serial_select_n_i) begin
      so_q <= 1'b0;
    end else if (read_mode && bit_cnt >= OPCODE_BITS && bit_cnt < OPCODE_BITS + LEN_16) begin
      so_q <= stat_hold[4'(6'd23 - bit_cnt)];
    end else begin
      so_q <= 1'b0;
    end
  end

  assign so_o = so_q;
  assign so_oe_o = read_mode & ~serial_select_n_i;

  // ---------------- System clock domain ----------------
  logic [1:0] sel_sync;
  logic [1:0] tog_sync;
  logic tog_seen;
  logic [1:0] lock_sync;
  logic pend;
  logic apply;
  logic [15:0] main_ctrl;
  logic [15:0] u_table;
  logic [15:0] v_table;
  logic [31:0] program_word;
  logic [39:0] copy_reg;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sel_sync <= 2'b11;
      tog_sync <= 2'b00;
      tog_seen <= 1'b0;
      lock_sync <= 2'b00;
    end else begin
      sel_sync <= {sel_sync[0], serial_select_n_i};
      tog_sync <= {tog_sync[0], cmd_toggle};
      tog_seen <= tog_sync[1];
      lock_sync <= {lock_sync[0], synth_locked_i};
    end
  end

  // Commit only once select is high
  // A new completion sets pending and holds off apply in the cycle it is seen
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pend <= 1'b0;
    end else if (tog_sync[1] != tog_seen) begin
      pend <= 1'b1;
    end else if (apply) begin
      pend <= 1'b0;
    end
  end

  assign apply = pend & sel_sync[1] & (tog_sync[1] == tog_seen);

  // Tables and program written at deselect
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      main_ctrl <= MAIN_CTRL_RST;
      u_table <= TABLE_RST;
      v_table <= TABLE_RST;
      program_word <= PROGRAM_RST;
      copy_reg <= COPY_ADDR_RST;
    end else if (apply) begin
      case (cmd_op)
        OP_MAIN_CTRL: main_ctrl <= cmd_data[15:0];
        OP_U_TABLE: u_table <= cmd_data[15:0];
        OP_V_TABLE: v_table <= cmd_data[15:0];
        OP_PROGRAM: program_word <= cmd_data[31:0];
        OP_COPY_ADDR: copy_reg <= cmd_data;
        default: main_ctrl <= main_ctrl;
      endcase
    end
  end

  assign copy_source_o = {copy_reg[CP_SRC_HI:CP_SRC_LO], copy_reg[CP_SRC_LSB_BIT]};
  assign copy_target_o = {copy_reg[CP_TGT_HI:CP_TGT_LO], copy_reg[CP_TGT_LSB_BIT]};
  assign luma_lowpass_on_o = copy_reg[CP_LOWPASS_BIT];
  assign output_current_high_o = copy_reg[CP_CURRENT_BIT];
  assign copy_busy_pin_o = copy_active_i;

  assign video_on_o = main_ctrl[MC_VIDEO_ON_BIT];
  assign pal_select_o = main_ctrl[MC_PAL_BIT];

  // ---------------- Timing ----------------
  logic [31:0] sc_acc;
  logic [32:0] sc_sum;
  logic [$clog2(PIXEL_DIV)-1:0] pix_div;
  logic [$clog2(LINE_PIXELS)-1:0] pix_in_line;
  logic [9:0] line;
  logic line_end;

  assign sc_sum = {1'b0, sc_acc} + {1'b0, pal_select_o ? PAL_SC_INC : NTSC_SC_INC};

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sc_acc <= 32'h0000_0000;
      subcarrier_tick_o <= 1'b0;
    end else if (!video_on_o) begin
      sc_acc <= 32'h0000_0000;
      subcarrier_tick_o <= 1'b0;
    end else begin
      sc_acc <= sc_sum[31:0];
      subcarrier_tick_o <= sc_sum[32];
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pix_div <= '0;
      pixel_tick_o <= 1'b0;
    end else if (!video_on_o) begin
      pix_div <= '0;
      pixel_tick_o <= 1'b0;
    end else begin
      pixel_tick_o <= (pix_div == ($clog2(PIXEL_DIV))'(PIXEL_DIV - 1));
      pix_div <= (pix_div == ($clog2(PIXEL_DIV))'(PIXEL_DIV - 1)) ? '0 : pix_div + 1'b1;
    end
  end

  assign line_end = pixel_tick_o && pix_in_line == ($clog2(LINE_PIXELS))'(LINE_PIXELS - 1);

  // Line counter wraps after total plus one
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pix_in_line <= '0;
      line <= 10'h000;
      index_restart_o <= 1'b0;
    end else if (!video_on_o) begin
      pix_in_line <= '0;
      line <= 10'h000;
      index_restart_o <= 1'b0;
    end else begin
      index_restart_o <= 1'b0;
      if (line_end) begin
        pix_in_line <= '0;
        if (line == main_ctrl[MC_LINES_HI:MC_LINES_LO]) begin
          line <= 10'h000;
          index_restart_o <= 1'b1;
        end else begin
          line <= line + 10'h001;
        end
      end else if (pixel_tick_o) begin
        pix_in_line <= pix_in_line + 1'b1;
      end
    end
  end

  assign current_line_o = line;
  // Index entries are three bytes apart from the start byte address
  assign line_index_addr_o = 17'({pic_index_start_i, 2'b00} + 17'(line) * 17'h00003);

  // Status snapshot before command
  // Held still while selected so the link side reads a stable word
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      stat_hold <= '0;
    end else if (sel_sync[1]) begin
      stat_hold <= '{synth_locked: lock_sync[1], copy_active_flag: copy_active_i,
                     unused: 4'h0, current_line: line};
    end
  end

  // ---------------- Microcode sequencer ----------------
  run_state_t run_state;
  logic [4:0] run_ticks;
  logic [4:0] run_len;
  logic [1:0] step_idx;
  logic [15:0] data_sr;
  step_t cur;
  logic [3:0] take_bits;
  logic [7:0] picked;
  logic run_start;

  assign run_len = protoline_i ? PROTO_RUN_TICKS : 5'(main_ctrl[MC_RUN_HI:MC_RUN_LO]) + 5'h01;
  assign run_start = pixel_tick_o && run_ticks == 5'h00;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      run_ticks <= 5'h00;
    end else if (!video_on_o || line_end) begin
      run_ticks <= 5'h00;
    end else if (pixel_tick_o) begin
      run_ticks <= (run_ticks == run_len - 5'h01) ? 5'h00 : run_ticks + 5'h01;
    end
  end

  assign cur = step_t'(program_word[{step_idx, 3'b000} +: 8]);
  assign take_bits = (cur.pick_code == PICK_U || cur.pick_code == PICK_V) && cur.bit_count > 3'h5 ?
                     UV_MAX_BITS : {1'b0, cur.bit_count} + 4'h1;
  assign picked = data_sr[7:0] & low_mask(take_bits);

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      run_state <= RUN_IDLE;
      step_idx <= 2'b00;
      data_sr <= 16'h0000;
      sram_req_o <= 1'b0;
    end else begin
      sram_req_o <= 1'b0;
      case (run_state)
        RUN_IDLE: begin
          if (video_on_o && run_start) begin
            data_sr <= sram_data_i;
            sram_req_o <= 1'b1;
            step_idx <= 2'b00;
            run_state <= RUN_EXEC;
          end
        end
        RUN_EXEC: begin
          data_sr <= data_sr >> cur.shift_amount;
          step_idx <= step_idx + 2'b01;
          if (step_idx == 2'b11 || !video_on_o) begin
            run_state <= RUN_IDLE;
          end
        end
        default: run_state <= RUN_IDLE;
      endcase
    end
  end

  // PAL negates V on odd lines
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      y_o <= 8'h00;
      u_o <= 6'h00;
      v_o <= 6'h00;
    end else if (run_state == RUN_EXEC) begin
      case (cur.pick_code)
        PICK_U: u_o <= chroma_translate_on_i ? {2'b00, table_entry(u_table, picked[1:0])} : picked[5:0];
        PICK_V: v_o <= pal_select_o && line[0] ?
                       6'(6'h00 - (chroma_translate_on_i ? {2'b00, table_entry(v_table, picked[1:0])} : picked[5:0])) :
                       (chroma_translate_on_i ? {2'b00, table_entry(v_table, picked[1:0])} : picked[5:0]);
        PICK_Y: y_o <= picked;
        default: y_o <= y_o;
      endcase
    end
  end
endmodule

// [bench/video_cmd_props.sv]
// Concurrent checks on the ports of the video command register block
`timescale 1ns/1ps
module video_cmd_props (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic serial_select_n_i,
  input wire logic so_oe_o,
  input wire logic copy_active_i,
  input wire logic copy_busy_pin_o,
  input wire logic protoline_i,
  input wire logic sram_req_o,
  input wire logic index_restart_o,
  input wire logic video_on_o,
  input wire logic pal_select_o,
  input wire logic pixel_tick_o,
  input wire logic subcarrier_tick_o,
  input wire logic luma_lowpass_on_o,
  input wire logic output_current_high_o,
  input wire logic [16:0] copy_source_o,
  input wire logic [9:0] current_line_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  logic pal_q;
  logic [5:0] sc_gap;
  logic sc_ok;
  logic [4:0] run_ticks;
  logic run_ok;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pal_q <= 1'b0;
    end else begin
      pal_q <= pal_select_o;
    end
  end
  // Gap between subcarrier ticks; a mode change voids the gap in flight
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sc_gap <= 6'h00;
      sc_ok <= 1'b0;
    end else if (subcarrier_tick_o) begin
      sc_gap <= 6'h01;
      sc_ok <= pal_q == pal_select_o && video_on_o;
    end else begin
      sc_gap <= sc_gap == 6'h3f ? sc_gap : sc_gap + 6'h01;
      sc_ok <= sc_ok && pal_q == pal_select_o && video_on_o;
    end
  end
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      run_ticks <= 5'h00;
      run_ok <= 1'b0;
    end else if (sram_req_o) begin
      run_ticks <= {4'h0, pixel_tick_o};
      run_ok <= protoline_i && video_on_o;
    end else begin
      run_ticks <= run_ticks + {4'h0, pixel_tick_o};
      // A line end cuts a run short, so runs spanning a line change are not judged
      run_ok <= run_ok && protoline_i && video_on_o && $stable(current_line_o);
    end
  end
  chk_busy_pin_mirror: assert property (copy_busy_pin_o == copy_active_i)
    else $error("copy busy pin differs from copy activity");
  chk_so_released: assert property (serial_select_n_i |-> !so_oe_o)
    else $error("serial output driven while deselected");
  chk_ticks_need_on: assert property (!video_on_o && !$past(video_on_o, 2) |-> !pixel_tick_o)
    else $error("pixel tick while generator off");
  chk_proto_run_len: assert property (sram_req_o && run_ok && protoline_i |-> run_ticks == 5'h08)
    else $error("protoline run is not eight pixel ticks");
  chk_restart_line_zero: assert property (index_restart_o |-> ##[0:1] current_line_o == 10'h000)
    else $error("index restart without line wrap");
  chk_line_steps_one: assert property (video_on_o && $changed(current_line_o)
    |-> current_line_o == $past(current_line_o) + 10'h001 || current_line_o == 10'h000)
    else $error("line counter jumped");
  chk_subcarrier_gap: assert property (subcarrier_tick_o && sc_ok
    |-> (pal_select_o ? sc_gap inside {6'd28, 6'd29} : sc_gap inside {6'd34, 6'd35}))
    else $error("subcarrier tick spacing wrong");
  chk_write_at_deselect: assert property ($changed({video_on_o, pal_select_o, luma_lowpass_on_o,
    output_current_high_o, copy_source_o}) |-> serial_select_n_i && $past(serial_select_n_i, 2))
    else $error("register changed while selected");
endmodule

// [bench/spi_host_model.sv]
// Serial host model that frames commands for the video command registers
`timescale 1ns/1ps
module spi_host_model (
  output logic sck_o,
  output logic sel_n_o,
  output logic si_o,
  input wire logic so_i
);
  initial begin
    sck_o = 1'b0;
    sel_n_o = 1'b1;
    si_o = 1'b0;
  end
  task automatic xfer(input logic [7:0] op, input logic [39:0] data, input int nbits, output logic [15:0] rd);
    rd = 16'h0000;
    sel_n_o = 1'b0;
    #80;
    for (int i = 0; i < 8 + nbits; i++) begin
      si_o = i < 8 ? op[7-i] : data[nbits+7-i];
      #80;
      sck_o = 1'b1;
      // status bits taken on rising clock
      if (i >= 8) rd = {rd[14:0], so_i};
      #80;
      sck_o = 1'b0;
    end
    sel_n_o = 1'b1;
    // Clock stands still and data flips from its last level between frames
    si_o = ~si_o;
    #200;
  endtask
endmodule

// [bench/video_gen_command_registers_test.sv]
// Self-checking bench for the video command register block
`timescale 1ns/1ps
module video_gen_command_registers_test;
  import video_cmd_pkg::*;
  logic mclk, rst, sck, sel_n, si, locked, copy_act, tr_on, proto;
  logic [13:0] pic_start;
  logic [15:0] sram_data, rd;
  logic so, so_oe, sram_req, restart, video_on, pal, pix, lowpass, cur_high, busy;
  logic [16:0] line_addr, src, tgt;
  logic [7:0] y;
  logic [5:0] u, v;
  logic [9:0] line;
  int failures = 0;
  int n_compared = 0;
  wire so_line = so_oe ? so : 1'bz;
  spi_host_model host (.sck_o(sck), .sel_n_o(sel_n), .si_o(si), .so_i(so_line));
  video_gen_command_registers #(.PIXEL_DIV(8), .LINE_PIXELS(16)) uut (.mclk_i(mclk), .rst_i(rst), .sck_i(sck),
    .serial_select_n_i(sel_n), .si_i(si), .so_o(so), .so_oe_o(so_oe), .synth_locked_i(locked),
    .copy_active_i(copy_act), .chroma_translate_on_i(tr_on), .protoline_i(proto), .pic_index_start_i(pic_start),
    .sram_data_i(sram_data), .sram_req_o(sram_req), .line_index_addr_o(line_addr), .index_restart_o(restart),
    .video_on_o(video_on), .pal_select_o(pal), .pixel_tick_o(pix), .subcarrier_tick_o(), .y_o(y), .u_o(u),
    .v_o(v), .luma_lowpass_on_o(lowpass), .output_current_high_o(cur_high), .copy_source_o(src),
    .copy_target_o(tgt), .copy_busy_pin_o(busy), .current_line_o(line));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic end_sim();
    $display("Compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [39:0] got, input logic [39:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Returns after the edge that samples the pulse; n counts edges waited
  task automatic wait_high(ref logic sig, output int n);
    n = 0;
    do begin
      @(posedge mclk);
      n++;
      if (n > 4000) begin
        failures++;
        $display("CHECK FAILED at %0t: wait ran out", $time);
        end_sim();
      end
    end while (sig !== 1'b1);
  endtask
  task automatic t_status();
    @(posedge mclk);
    locked <= 1'b1;
    copy_act <= 1'b1;
    // Lock crosses a two-stage synchroniser before the snapshot can see it
    repeat (4) @(posedge mclk);
    host.xfer(OP_STATUS, 40'h0, 16, rd);
    check(rd, 16'hc000, "status with lock and copy");
    check(busy, 1'b1, "busy pin");
    @(posedge mclk);
    locked <= 1'b0;
    copy_act <= 1'b0;
    repeat (4) @(posedge mclk);
    host.xfer(OP_STATUS, 40'h0, 16, rd);
    check(rd, 16'h0000, "status idle");
    $display("test status done");
  endtask
  task automatic t_copy();
    host.xfer(OP_COPY_ADDR, 40'hbeef_1234_16, 40, rd);
    check({src, tgt, lowpass, cur_high}, {16'hbeef, 1'b1, 16'h1234, 1'b1, 2'b10}, "copy fields");
    host.xfer(OP_COPY_ADDR, 40'h00_0000_0008, 40, rd);
    check({src, tgt, lowpass, cur_high}, {34'h0, 2'b01}, "copy current");
    host.xfer(OP_COPY_ADDR, 40'hff_ffff_ffff, 20, rd);
    host.xfer(8'h31, 40'hff_ffff_ffff, 40, rd);
    check({src, tgt, cur_high}, {34'h0, 1'b1}, "aborted or unknown frame");
    $display("test copy register done");
  endtask
  task automatic t_video();
    int n;
    int ticks;
    host.xfer(OP_U_TABLE, 40'h4321, 16, rd);
    host.xfer(OP_V_TABLE, 40'h8765, 16, rd);
    // word holds Y then U then V as the steps take them
    host.xfer(OP_PROGRAM, 40'hc04a0abe, 32, rd);
    host.xfer(OP_MAIN_CTRL, 40'h8801, 16, rd);
    check({video_on, pal}, 2'b10, "generator on, NTSC");
    wait_high(sram_req, n);
    ticks = 0;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
      ticks += int'(pix === 1'b1);
    end while (sram_req !== 1'b1 && ticks < 100 && n < 4000);
    check(40'(ticks), 40'd3, "normal run length");
    repeat (6) @(posedge mclk);
    check(y, 8'h5a, "luma pick");
    check(u, 6'h02, "U table entry");
    check(v, 6'h08, "V table entry");
    wait_high(restart, n);
    check(line_addr, {1'b0, pic_start, 2'b00}, "index restart address");
    wait_high(restart, n);
    check(40'(n), 40'd256, "two lines between restarts");
    $display("test video run done");
  endtask
  task automatic t_proto_pal();
    int n;
    host.xfer(OP_MAIN_CTRL, 40'hc801, 16, rd);
    check(pal, 1'b1, "PAL selected");
    proto <= 1'b1;
    repeat (3) wait_high(sram_req, n);
    // Long enough for several whole protoline runs across two lines
    repeat (32) wait_high(pix, n);
    host.xfer(OP_MAIN_CTRL, 40'h0801, 16, rd);
    check(video_on, 1'b0, "generator off");
    host.xfer(OP_STATUS, 40'h0, 16, rd);
    check(rd[15:10], 6'h00, "status upper bits");
    $display("test protoline and PAL done");
  endtask
  initial begin
    rst = 1'b1;
    locked = 1'b0;
    copy_act = 1'b0;
    tr_on = 1'b1;
    proto = 1'b0;
    pic_start = 14'h0123;
    sram_data = 16'h0b5a;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    check({video_on, src, line}, 28'h0, "reset values");
    t_status();
    t_copy();
    t_video();
    t_proto_pal();
    end_sim();
  end
endmodule
bind video_gen_command_registers video_cmd_props chk (.mclk_i, .rst_i, .serial_select_n_i, .so_oe_o, .copy_active_i,
  .copy_busy_pin_o, .protoline_i, .sram_req_o, .index_restart_o, .video_on_o, .pal_select_o, .pixel_tick_o,
  .subcarrier_tick_o, .luma_lowpass_on_o, .output_current_high_o, .copy_source_o, .current_line_o);
